/* File: hdl/switch_global_config_regs.sv */
// switch_global_config_regs: global configuration bytes 0x08-0x0f of a three-port switch
// assumes a byte-wide register port from the management/host interface on clk_i
// Notes on behaviour
// [R1] two-bit field bits 7-6 chooses interface clock 31.25/62.5/125 MHz; resets to 10
// [R2] host should pick 31.25 MHz when fast access is not needed, saving power
// [R3] tag 0-3 priority from low map register bit pairs 1-0 through 7-6
// [R4] low map resets tags 0,1 to 00 and tags 2,3 to 01
// [R5] tags 4-7 use high map register pairs; reset 10,10,11,11
// [R6] bit 7 enables sending unknown-destination frames only to masked ports; reset 0
// [R7] mask bits 2-0 select ports 1-3, one includes; resets to 111
// [R8] bit 6 drives pads: one 16mA, zero 8mA; resets to one
// [R9] bits 7-3 give port 1 PHY address, 1..29 valid; resets 00001
// [R10] port 2 PHY address is port 1 address plus one
// [R11] test registers 0x08-0x0a read-only 0x00, 0x24, 0x35
// [R12] clock register bits 5-0 read-only as 001000
// [R13] unknown reg bits 5,3 writable reset 0, bit 4 zero; PHY bits 2-0 zero
// [R14] read-only bits ignore writes; fields hold reset values until written
`timescale 1ns/100ps
module switch_global_config_regs
	import glob_cfg_pkg::*;
(
	// clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_n_i,
	// register port
	input  wire logic [7:0] reg_addr_i,
	input  wire logic       reg_wr_i,
	input  wire logic [7:0] reg_wdata_i,
	output logic      [7:0] reg_rdata_o,
	// interface clock select
	output logic      [1:0] if_clk_sel_o,
	// priority lookup
	input  wire logic [2:0] tag_i,
	output logic      [1:0] tag_prio_o,
	// unknown destination forwarding
	output logic            unknown_fwd_en_o,
	output logic      [2:0] unknown_port_mask_o,
	// pads and phy addressing
	output logic            pad_drive_16ma_o,
	output logic      [4:0] port1_phy_addr_o,
	output logic      [4:0] port2_phy_addr_o,
	output logic            phy_addr_valid_o
);
	logic [1:0] clk_sel;
	logic [7:0] prio_low;
	logic [7:0] prio_high;
	logic [7:0] unknown_cfg;
	logic [4:0] phy_base;
	logic [1:0] next_clk_sel;
	logic [7:0] next_prio_low;
	logic [7:0] next_prio_high;
	logic [7:0] next_unknown_cfg;
	logic [4:0] next_phy_base;
	logic [1:0] past_clk_sel;

	// write decode; read-only bits never take write data
	always_comb begin
		next_clk_sel     = clk_sel;
		next_prio_low    = prio_low;
		next_prio_high   = prio_high;
		next_unknown_cfg = unknown_cfg;
		next_phy_base    = phy_base;
		if (reg_wr_i) begin
			case (reg_addr_i)
				OFF_CLK_SEL:   next_clk_sel     = reg_wdata_i[CLK_SEL_LSB +: 2]; // R1 R12
				OFF_PRIO_LOW:  next_prio_low    = reg_wdata_i; // R3
				OFF_PRIO_HIGH: next_prio_high   = reg_wdata_i; // R5
				OFF_UNKNOWN:   next_unknown_cfg = reg_wdata_i & UNKNOWN_WMASK; // R13
				OFF_PHY_BASE:  next_phy_base    = reg_wdata_i[PHY_LSB +: 5]; // R9
				default:       next_clk_sel     = clk_sel; // R11 R14
			endcase
		end
	end

	// register state, reset values on system reset
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			clk_sel      <= RST_CLK_SEL; // R1
			prio_low     <= RST_PRIO_LOW; // R4
			prio_high    <= RST_PRIO_HIGH; // R5
			unknown_cfg  <= RST_UNKNOWN; // R6 R7 R8 R13
			phy_base     <= RST_PHY_BASE; // R9
			past_clk_sel <= RST_CLK_SEL;
		end else begin
			clk_sel      <= next_clk_sel; // R14
			prio_low     <= next_prio_low;
			prio_high    <= next_prio_high;
			unknown_cfg  <= next_unknown_cfg;
			phy_base     <= next_phy_base;
			past_clk_sel <= clk_sel;
		end
	end

	// read mux, unmapped offsets read zero
	always_comb begin
		case (reg_addr_i)
			OFF_TEST_A:    reg_rdata_o = RST_TEST_A; // R11
			OFF_TEST_B:    reg_rdata_o = RST_TEST_B; // R11
			OFF_TEST_C:    reg_rdata_o = RST_TEST_C; // R11
			OFF_CLK_SEL:   reg_rdata_o = {clk_sel, CLK_SEL_RSVD}; // R12
			OFF_PRIO_LOW:  reg_rdata_o = prio_low;
			OFF_PRIO_HIGH: reg_rdata_o = prio_high;
			OFF_UNKNOWN:   reg_rdata_o = unknown_cfg; // R13
			OFF_PHY_BASE:  reg_rdata_o = {phy_base, 3'h0}; // R13
			default:       reg_rdata_o = 8'h00;
		endcase
	end

	// configuration outputs toward the switch core
	// port 2 address is cut to five bits on purpose, so 11111 wraps to 00000
	// invalid base codes are kept as written and only flagged through phy_addr_valid_o
	always_comb begin
		if_clk_sel_o        = clk_sel; // R1
		unknown_fwd_en_o    = unknown_cfg[UNK_EN_BIT]; // R6
		unknown_port_mask_o = unknown_cfg[2:0]; // R7
		pad_drive_16ma_o    = unknown_cfg[DRIVE_BIT]; // R8
		port1_phy_addr_o    = phy_base; // R9
		port2_phy_addr_o    = 5'(phy_base + 5'h01); // R10
		phy_addr_valid_o    = (phy_base != 5'h00) && (phy_base <= PHY_LAST_VALID); // R9
	end

	// tag to priority lookup
	prio_lookup u_prio (
		.map_low_i  (prio_low),
		.map_high_i (prio_high),
		.tag_i      (tag_i),
		.prio_o     (tag_prio_o)
	);

	// register write, hold and read checks
	a_clk_sel_write: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R1
		reg_wr_i && reg_addr_i == OFF_CLK_SEL |=> if_clk_sel_o == $past(reg_wdata_i[7:6]))
		else $error("clock select not written");
	a_clk_rsvd_const: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R12
		reg_addr_i == OFF_CLK_SEL |-> reg_rdata_o[5:0] == 6'h08)
		else $error("clock reserved bits wrong");
	a_clk_sel_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R14
		!(reg_wr_i && reg_addr_i == OFF_CLK_SEL) |=> clk_sel == past_clk_sel)
		else $error("clock select changed without write");
	a_prio_low_map: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R3
		tag_i == 3'h3 |-> tag_prio_o == prio_low[7:6])
		else $error("tag three priority wrong");
	a_prio_high_map: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R5
		tag_i == 3'h4 |-> tag_prio_o == prio_high[1:0])
		else $error("tag four priority wrong");
	a_test_reg_ro: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R11
		reg_addr_i == OFF_TEST_C |-> reg_rdata_o == 8'h35)
		else $error("test register c wrong");
	a_unknown_bit4: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R13
		reg_wr_i && reg_addr_i == OFF_UNKNOWN ##1 reg_addr_i == OFF_UNKNOWN |-> reg_rdata_o[4] == 1'b0)
		else $error("reserved bit 4 not zero");
	a_unknown_mask: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R7
		reg_wr_i && reg_addr_i == OFF_UNKNOWN |=> unknown_port_mask_o == $past(reg_wdata_i[2:0]))
		else $error("port mask not written");
	a_port2_phy: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R10
		port2_phy_addr_o == port1_phy_addr_o + 5'h01)
		else $error("port 2 phy address wrong");
	a_drive_write: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R8
		reg_wr_i && reg_addr_i == OFF_UNKNOWN |=> pad_drive_16ma_o == $past(reg_wdata_i[6]))
		else $error("drive strength not written");

	// reset values, sampled at the first edge after release
	a_reset_clk_sel: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R1
		$rose(rst_n_i) |-> if_clk_sel_o == 2'h2)
		else $error("clock select reset value wrong");
	a_reset_prio_maps: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R4 R5
		$rose(rst_n_i) |-> prio_low == 8'h50 && prio_high == 8'hfa)
		else $error("priority map reset value wrong");
	a_reset_unknown: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R6 R7 R8
		$rose(rst_n_i) |-> !unknown_fwd_en_o && unknown_port_mask_o == 3'h7 && pad_drive_16ma_o)
		else $error("unknown forwarding reset value wrong");
	a_reset_phy_base: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R9
		$rose(rst_n_i) |-> port1_phy_addr_o == 5'h01)
		else $error("phy base reset value wrong");

	// writes land one edge after the strobe, other offsets leave state alone
	a_prio_low_write: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R3
		reg_wr_i && reg_addr_i == OFF_PRIO_LOW |=> prio_low == $past(reg_wdata_i))
		else $error("low priority map not written");
	a_prio_high_write: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R5
		reg_wr_i && reg_addr_i == OFF_PRIO_HIGH |=> prio_high == $past(reg_wdata_i))
		else $error("high priority map not written");
	a_phy_base_write: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R9
		reg_wr_i && reg_addr_i == OFF_PHY_BASE |=> port1_phy_addr_o == $past(reg_wdata_i[7:3]))
		else $error("phy base not written");
	a_unknown_enable: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R6
		reg_wr_i && reg_addr_i == OFF_UNKNOWN |=> unknown_fwd_en_o == $past(reg_wdata_i[7]))
		else $error("forwarding enable not written");
	a_unknown_rsvd_bits: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R13
		reg_wr_i && reg_addr_i == OFF_UNKNOWN |=>
		unknown_cfg[5:3] == {$past(reg_wdata_i[5]), 1'b0, $past(reg_wdata_i[3])})
		else $error("reserved unknown bits wrong");
	a_unmapped_write: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R11 R14
		reg_wr_i && (reg_addr_i < OFF_CLK_SEL || reg_addr_i > OFF_PHY_BASE) |=>
		$stable({clk_sel, prio_low, prio_high, unknown_cfg, phy_base}))
		else $error("state changed on read-only write");

	// read path and fixed bytes
	a_test_a_ro: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R11
		reg_addr_i == OFF_TEST_A |-> reg_rdata_o == 8'h00)
		else $error("test register a wrong");
	a_test_b_ro: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R11
		reg_addr_i == OFF_TEST_B |-> reg_rdata_o == 8'h24)
		else $error("test register b wrong");
	a_clk_read_back: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R1
		reg_addr_i == OFF_CLK_SEL |-> reg_rdata_o[7:6] == if_clk_sel_o)
		else $error("clock select read back wrong");
	a_prio_low_read: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R3
		reg_addr_i == OFF_PRIO_LOW |-> reg_rdata_o == prio_low)
		else $error("low priority map read back wrong");
	a_prio_high_read: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R5
		reg_addr_i == OFF_PRIO_HIGH |-> reg_rdata_o == prio_high)
		else $error("high priority map read back wrong");
	a_unknown_read_back: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R6 R7 R8
		reg_addr_i == OFF_UNKNOWN |->
		reg_rdata_o == {unknown_fwd_en_o, pad_drive_16ma_o, unknown_cfg[5:3], unknown_port_mask_o})
		else $error("unknown register read back wrong");
	a_phy_read_back: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R9 R13
		reg_addr_i == OFF_PHY_BASE |-> reg_rdata_o == {port1_phy_addr_o, 3'h0})
		else $error("phy base read back wrong");

	// lookup at the two ends of the map
	a_prio_tag_zero: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R3
		tag_i == 3'h0 |-> tag_prio_o == prio_low[1:0])
		else $error("tag zero priority wrong");
	a_prio_tag_seven: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R5
		tag_i == 3'h7 |-> tag_prio_o == prio_high[7:6])
		else $error("tag seven priority wrong");

	// phy address validity flag
	a_phy_valid_flag: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R9
		phy_addr_valid_o == !(port1_phy_addr_o inside {5'h00, 5'h1e, 5'h1f}))
		else $error("phy valid flag wrong");
endmodule : switch_global_config_regs

/* File: hdl/glob_cfg_pkg.sv */
// glob_cfg_pkg: offsets, field positions and reset values of the global configuration bank
// assumes byte-wide register access with 8-bit offsets
package glob_cfg_pkg;
	localparam logic [7:0] OFF_TEST_A      = 8'h08;
	localparam logic [7:0] OFF_TEST_B      = 8'h09;
	localparam logic [7:0] OFF_TEST_C      = 8'h0a;
	localparam logic [7:0] OFF_CLK_SEL     = 8'h0b;
	localparam logic [7:0] OFF_PRIO_LOW    = 8'h0c;
	localparam logic [7:0] OFF_PRIO_HIGH   = 8'h0d;
	localparam logic [7:0] OFF_UNKNOWN     = 8'h0e;
	localparam logic [7:0] OFF_PHY_BASE    = 8'h0f;
	localparam logic [7:0] RST_TEST_A      = 8'h00;
	localparam logic [7:0] RST_TEST_B      = 8'h24;
	localparam logic [7:0] RST_TEST_C      = 8'h35;
	localparam logic [1:0] RST_CLK_SEL     = 2'h2;
	localparam logic [5:0] CLK_SEL_RSVD    = 6'h08;
	localparam logic [7:0] RST_PRIO_LOW    = 8'h50;
	localparam logic [7:0] RST_PRIO_HIGH   = 8'hfa;
	localparam logic [7:0] RST_UNKNOWN     = 8'h47;
	localparam logic [7:0] UNKNOWN_WMASK   = 8'hef;
	localparam logic [4:0] RST_PHY_BASE    = 5'h01;
	localparam int         CLK_SEL_LSB     = 6;
	localparam int         UNK_EN_BIT      = 7;
	localparam int         DRIVE_BIT       = 6;
	localparam int         PHY_LSB         = 3;
	localparam logic [1:0] CLK_31M         = 2'h0;
	localparam logic [1:0] CLK_62M         = 2'h1;
	localparam logic [1:0] CLK_125M        = 2'h2;
	localparam logic [4:0] PHY_LAST_VALID  = 5'h1d;
endpackage : glob_cfg_pkg

/* File: hdl/prio_lookup.sv */
// prio_lookup: picks the two-bit egress priority for a three-bit 802.1p tag
// assumes the two mapping bytes come from the register bank on the same clock
`timescale 1ns/100ps
module prio_lookup (
	// mapping registers
	input  wire logic [7:0] map_low_i,
	input  wire logic [7:0] map_high_i,
	// lookup
	input  wire logic [2:0] tag_i,
	output logic      [1:0] prio_o
);
	logic [15:0] table_bits;

	// tags 0-3 in low byte, 4-7 in high byte, two bits per tag
	always_comb begin
		table_bits = {map_high_i, map_low_i};
		prio_o     = table_bits[{tag_i, 1'b0} +: 2]; // R3 R5
	end
endmodule : prio_lookup

/* File: verif/tb_top.sv */
// tb_top: self-checking bench for the global configuration register bank
// assumes byte writes are taken on a rising edge and reads are combinational
`timescale 1ns/100ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin mismatches++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_top;
	import glob_cfg_pkg::*;
	logic       clk_i;
	logic       rst_n_i;
	logic [7:0] reg_addr_i;
	logic       reg_wr_i;
	logic [7:0] reg_wdata_i;
	logic [7:0] reg_rdata_o;
	logic [1:0] if_clk_sel_o;
	logic [2:0] tag_i;
	logic [1:0] tag_prio_o;
	logic       unknown_fwd_en_o;
	logic [2:0] unknown_port_mask_o;
	logic       pad_drive_16ma_o;
	logic [4:0] port1_phy_addr_o;
	logic [4:0] port2_phy_addr_o;
	logic       phy_addr_valid_o;
	int         mismatches;
	int         check_count;
	logic [7:0] rst_vals [8] = '{8'h00, 8'h24, 8'h35, 8'h88, 8'h50, 8'hfa, 8'h47, 8'h08};
	logic [1:0] prio_exp [8] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h3, 2'h2, 2'h1, 2'h0};
	// device under test
	switch_global_config_regs i_switch_global_config_regs (.clk_i(clk_i), .rst_n_i(rst_n_i),
		.reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i),
		.reg_rdata_o(reg_rdata_o), .if_clk_sel_o(if_clk_sel_o), .tag_i(tag_i), .tag_prio_o(tag_prio_o),
		.unknown_fwd_en_o(unknown_fwd_en_o), .unknown_port_mask_o(unknown_port_mask_o),
		.pad_drive_16ma_o(pad_drive_16ma_o), .port1_phy_addr_o(port1_phy_addr_o),
		.port2_phy_addr_o(port2_phy_addr_o), .phy_addr_valid_o(phy_addr_valid_o));
	// 25 MHz core clock
	always #20 clk_i = ~clk_i;
	// one-cycle write strobe, released at the next edge
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		reg_addr_i  <= a;
		reg_wdata_i <= d;
		reg_wr_i    <= 1'b1;
		@(posedge clk_i);
		reg_wr_i    <= 1'b0;
	endtask : wr
	// read back at the falling edge, where the data has settled
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk_i);
		reg_addr_i <= a;
		@(negedge clk_i);
		`CHK(reg_rdata_o, e)
	endtask : rd
	// verdict
	task automatic wrap_up;
		$display("mismatches=%0d check_count=%0d", mismatches, check_count);
		if (mismatches == 0 && check_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : wrap_up
	initial begin
		clk_i = 1'b0; rst_n_i = 1'b0; reg_addr_i = 8'h00; reg_wr_i = 1'b0;
		reg_wdata_i = 8'h00; tag_i = 3'h0; mismatches = 0; check_count = 0;
		repeat (2) @(posedge clk_i);
		rst_n_i <= 1'b1;
		// reset values of every byte and of the derived outputs
		for (int i = 0; i < 8; i++) rd(8'h08 + 8'(i), rst_vals[i]);
		`CHK({if_clk_sel_o, unknown_fwd_en_o, unknown_port_mask_o, pad_drive_16ma_o}, 7'h4f)
		`CHK({port1_phy_addr_o, port2_phy_addr_o, phy_addr_valid_o}, 11'h045)
		// an unmapped byte ignores writes; test bytes are left alone and keep their values
		wr(8'h10, 8'hff);
		for (int i = 0; i < 3; i++) rd(8'h08 + 8'(i), rst_vals[i]);
		rd(8'h10, 8'h00);
		// every interface clock code, reserved bits fixed
		for (int c = 0; c < 3; c++) begin
			wr(OFF_CLK_SEL, {2'(c), 6'h3f});
			rd(OFF_CLK_SEL, {2'(c), 6'h08});
			`CHK(if_clk_sel_o, 2'(c))
		end
		wr(OFF_CLK_SEL, {CLK_31M, 6'h00});
		// priority maps, two writes with an idle cycle between, every tag value
		wr(OFF_PRIO_LOW, 8'he4);
		wr(OFF_PRIO_HIGH, 8'h1b);
		for (int t = 0; t < 8; t++) begin
			@(posedge clk_i);
			tag_i <= 3'(t);
			@(negedge clk_i);
			`CHK(tag_prio_o, prio_exp[t])
		end
		// unknown destination forwarding, bit 4 stays zero
		wr(OFF_UNKNOWN, 8'hd7);
		rd(OFF_UNKNOWN, 8'hc7);
		`CHK({unknown_fwd_en_o, unknown_port_mask_o, pad_drive_16ma_o}, 5'h1f)
		wr(OFF_UNKNOWN, 8'h02);
		rd(OFF_UNKNOWN, 8'h02);
		`CHK({unknown_fwd_en_o, unknown_port_mask_o, pad_drive_16ma_o}, 5'h04)
		// phy base: last valid code, first invalid, zero
		wr(OFF_PHY_BASE, 8'hef);
		rd(OFF_PHY_BASE, 8'he8);
		`CHK({port1_phy_addr_o, port2_phy_addr_o, phy_addr_valid_o}, 11'h77d)
		wr(OFF_PHY_BASE, 8'hf0);
		@(negedge clk_i);
		`CHK({port1_phy_addr_o, port2_phy_addr_o, phy_addr_valid_o}, 11'h7be)
		wr(OFF_PHY_BASE, 8'h00);
		@(negedge clk_i);
		`CHK({port1_phy_addr_o, port2_phy_addr_o, phy_addr_valid_o}, 11'h002)
		// a second reset restores every writable byte, 0x0b-0x0f
		@(posedge clk_i);
		rst_n_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		rst_n_i <= 1'b1;
		for (int i = 3; i < 8; i++) rd(8'h08 + 8'(i), rst_vals[i]);
		wrap_up();
	end
endmodule : tb_top
